// ---- common/l2cc_pkg.sv ----
// Constants, types and layouts shared by the secondary-cache controller
//
// Overview of operation
// [RULE1] Cacheable-cycle input sampled with the address strobe decides burst versus single.
// [RULE2] Read hit: first word after one wait state, then three more at one each.
// [RULE3] Tag match sampled at end of first T2; burst-ready follows next clock.
// [RULE4] Programmed cache wait states stretch the leadoff before burst-ready.
// [RULE5] Two banks: A4 is SRAM low address, A3 picks bank, enables alternate.
// [RULE6] One bank: A3 is SRAM low address, even output enable held whole cycle.
// [RULE7] Write-through hit writes cache and memory; burst-ready after memory finishes.
// [RULE8] Write-back hit writes cache only, sets dirty; bursts only if cacheable.
// [RULE9] Write-back burst runs 3-2-2-2 async, 2-1-1-1 style gaps on sync SRAM.
// [RULE10] Bank write enables come from A3 and interleave through the burst.
// [RULE11] Chip selects follow the processor byte enables on cache writes.
// [RULE12] Clean read miss: linefill from memory to cache and processor, tag updated.
// [RULE13] Non-cacheable read miss fetches eight bytes only, tag and dirty untouched.
// [RULE14] Dirty read miss: castout first, tag and dirty updated, then linefill.
// [RULE15] Write miss goes to memory only, posted when posting and buffer allow.
// [RULE16] Cycles not aimed at system memory leave the controller idle.
// [RULE17] Write policy comes from bits 5:4 of index 02h; hits always update cache.
// [RULE18] Adaptive policy writes through only on a DRAM page hit.
// [RULE19] First adaptive mode also needs the row strobe active.
// [RULE20] Second adaptive mode writes through on any page hit.
// [RULE21] 64KB: tag bits 0..7 compare A16..A23; bits 5..7 always A21..A23.
// [RULE22] Each size doubling moves the next tag bit up to A24..A28.
// [RULE23] Hit needs tag match and cacheable location; others are misses.
// [RULE24] Burst quad-word order interleaved or linear by index 17h bit 0.
`default_nettype none
package l2cc_pkg;
  // ---------------------------------------------------------------
  // Register map, byte address is index times four
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_POLICY = 5'h02;
  localparam logic [4:0] IDX_CTRL = 5'h03;
  localparam logic [4:0] IDX_STATUS = 5'h04;
  localparam logic [4:0] IDX_BURST = 5'h17;
  localparam int POLICY_LSB = 4;
  localparam int BURST_LINEAR_BIT = 0;
  localparam logic [1:0] POLICY_RST = 2'h0;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic BURST_RST = 1'b0;

  // ---------------------------------------------------------------
  // Size codes and cycle counts
  // ---------------------------------------------------------------
  localparam int TAG_MOVABLE = 5;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [1:0] FIRST_BEAT = 2'h0;

  typedef enum logic [1:0] {
    POL_WRITE_BACK = 2'h0,
    POL_WRITE_THROUGH = 2'h1,
    POL_ADAPTIVE_WB_ROW_ACTIVE = 2'h2,
    POL_ADAPTIVE_WB_PAGE_ONLY = 2'h3
  } l2cc_policy_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_T2 = 3'h1,
    ST_LEAD = 3'h3,
    ST_BEAT = 3'h2,
    ST_MEM = 3'h6,
    ST_CAST = 3'h7,
    ST_FILL = 3'h5
  } l2cc_state_type;

  // Size 0 = 64KB up to 5 = 2MB
  typedef struct packed {
    logic cache_en;
    logic post_en;
    logic sync_sram;
    logic two_bank;
    logic [1:0] waits;
    logic [2:0] size;
  } l2cc_ctrl_type;

  typedef struct packed {
    logic ads_n;
    logic [31:3] addr;
    logic wr;
    logic cache_n;
    logic [7:0] byte_lane_en_n;
    logic sysmem;
    logic noncache;
  } l2cc_cpu_type;

  typedef struct packed {
    logic [7:0] tag;
    logic dirty;
    logic mem_done;
    logic mem_beat;
    logic page_hit;
    logic row_active;
    logic wbuf_avail;
  } l2cc_ext_type;
endpackage
`default_nettype wire

// ---- dv/l2cc_checker.sv ----
// Port-level assertions for the secondary-cache controller
`default_nettype none
module l2cc_checker import l2cc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire l2cc_cpu_type cpu_i,
  input wire logic burst_ready_n_o,
  input wire logic odd_bank_out_en_n_o,
  input wire logic even_bank_out_en_n_o,
  input wire logic odd_bank_wr_en_n_o,
  input wire logic even_bank_wr_en_n_o,
  input wire logic [7:0] sram_cs_n_o,
  input wire logic tag_wr_en_n_o,
  input wire logic mem_req_o,
  input wire logic mem_wr_o,
  input wire logic mem_line_o,
  input wire logic mem_castout_o,
  input wire logic mem_posted_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic we_any;
  // ---------------
  // Checks
  // ---------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  assign we_any = !odd_bank_wr_en_n_o || !even_bank_wr_en_n_o;
  chk_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("waitrequest timing wrong");
  chk_reset_quiet: assert property ($rose(nrst_i) |-> burst_ready_n_o && tag_wr_en_n_o &&
    !mem_req_o && sram_cs_n_o == 8'hff) else $error("active after reset");
  chk_oe_exclusive: assert property (odd_bank_out_en_n_o || even_bank_out_en_n_o)
    else $error("two output enables");
  chk_we_exclusive: assert property (odd_bank_wr_en_n_o || even_bank_wr_en_n_o)
    else $error("two write enables");
  chk_cs_bytes: assert property (we_any && cpu_i.wr && !mem_req_o |->
    sram_cs_n_o == cpu_i.byte_lane_en_n) else $error("chip selects off lanes");
  chk_we_ready: assert property (we_any && cpu_i.wr |-> !burst_ready_n_o)
    else $error("write without ready");
  chk_posted_pulse: assert property (mem_posted_o |-> mem_req_o && mem_wr_o ##1 !mem_req_o)
    else $error("posted not one pulse");
  chk_castout_line: assert property (mem_castout_o |-> mem_req_o && mem_wr_o && mem_line_o)
    else $error("castout not a line write");
  chk_req_holds: assert property ($rose(mem_req_o) && !mem_posted_o |=> mem_req_o [*2])
    else $error("request dropped early");
endmodule
bind l2cc_top l2cc_checker i_l2cc_checker (.*);
`default_nettype wire

// ---- dv/l2cc_far_model.sv ----
// Behavioural model of the tag store and the system-memory controller
`default_nettype none
module l2cc_far_model import l2cc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic mem_req_i,
  input wire logic mem_line_i,
  input wire logic tag_wr_en_n_i,
  input wire logic dirty_wr_en_n_i,
  input wire logic dirty_i,
  input wire logic [7:0] tag_i,
  input wire logic ld_i,
  input wire logic ld_dirty_i,
  input wire logic [7:0] ld_tag_i,
  input wire logic page_hit_i,
  input wire logic row_active_i,
  input wire logic wbuf_avail_i,
  input wire logic [3:0] lat_i,
  output var l2cc_ext_type ext_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // ---------------
  // Memory answers
  // ---------------
  // Latency of three or more stops a dropping request drawing a second answer
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt <= 4'h0;
      ext_o <= '0;
    end else begin
      ext_o.page_hit <= page_hit_i;
      ext_o.row_active <= row_active_i;
      ext_o.wbuf_avail <= wbuf_avail_i;
      ext_o.mem_done <= 1'b0;
      ext_o.mem_beat <= 1'b0;
      if (ld_i) begin
        ext_o.tag <= ld_tag_i;
        ext_o.dirty <= ld_dirty_i;
      end else begin
        if (!tag_wr_en_n_i) ext_o.tag <= tag_i;
        if (!dirty_wr_en_n_i) ext_o.dirty <= dirty_i;
      end
      cnt <= mem_req_i ? cnt + 4'h1 : 4'h0;
      if (mem_req_i && cnt == lat_i) begin
        cnt <= 4'h0;
        ext_o.mem_beat <= mem_line_i;
        ext_o.mem_done <= !mem_line_i;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking testbench for the secondary-cache controller
`default_nettype none
module tb import l2cc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [6:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o, q;
  logic avs_waitrequest_o, burst_ready_n_o, odd_bank_out_en_n_o, even_bank_out_en_n_o, odd_bank_wr_en_n_o;
  logic even_bank_wr_en_n_o, sram_addr_lsb_o, tag_wr_en_n_o, dirty_o, dirty_wr_en_n_o, mem_req_o, mem_wr_o;
  logic mem_line_o, mem_castout_o, mem_posted_o, req, line, cast, post, mwr, tagw, eoe, ooe;
  logic [7:0] sram_cs_n_o, tag_o, cs, tg, tm;
  logic [7:0] ltag = '0;
  logic ld = 1'b0, ldd = 1'b0, ph = 1'b0, ra = 1'b0, wb = 1'b0;
  logic [3:0] lt = 4'h4, lsq, osq;
  logic [1:0] dw;
  l2cc_cpu_type cpu_i = '1;
  l2cc_ext_type ext_i;
  int num_errors = 0, n_compared = 0, nr, fst, gp, lst, nwe, f0, k;
  localparam logic [31:3] A = 29'h02b4a001;
  always #20 ref_clk_i = ~ref_clk_i;
  l2cc_top i_l2cc_top (.*);
  l2cc_far_model i_l2cc_far_model (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .mem_req_i(mem_req_o),
    .mem_line_i(mem_line_o), .tag_wr_en_n_i(tag_wr_en_n_o), .dirty_wr_en_n_i(dirty_wr_en_n_o),
    .dirty_i(dirty_o), .tag_i(tag_o), .ld_i(ld), .ld_dirty_i(ldd), .ld_tag_i(ltag), .page_hit_i(ph),
    .row_active_i(ra), .wbuf_avail_i(wb), .lat_i(lt), .ext_o(ext_i));
  // ---------------
  // Tasks
  // ---------------
  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic to();
    num_errors++;
    $display("Error at %0t: timeout", $time);
    summarize();
  endtask
  task automatic av(input logic [4:0] ix, input logic w, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    avs_address_i <= {ix, 2'b00};
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk_i);
      if (!avs_waitrequest_o) break;
    end
    if (n == 20) to();
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] ix, input logic [31:0] d);
    av(ix, 1'b1, d);
  endtask
  task automatic rd(input logic [4:0] ix, input logic [31:0] e);
    av(ix, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic cfg(input logic [2:0] sz, input logic [1:0] wt, input logic b2, sy, po);
    wr(5'h03, {23'h0, 1'b1, po, sy, b2, wt, sz});
  endtask
  task automatic setx(input logic [7:0] t, input logic d);
    @(posedge ref_clk_i);
    {ltag, ldd, ld} <= {t, d, 1'b1};
    @(posedge ref_clk_i);
    ld <= 1'b0;
  endtask
  function automatic logic [7:0] tagof(input logic [31:3] a, input int sz);
    for (int i = 0; i < 8; i++) tagof[i] = (i < sz && i < 5) ? a[24 + i] : a[16 + i];
  endfunction
  // One processor cycle, gathering output activity
  task automatic run(input logic [31:3] a, input logic w, c, input logic [7:0] b, input logic s, n,
    input int ex);
    int t;
    {req, line, cast, post, mwr, tagw, eoe, ooe, dw, lsq, osq, tg} = '0;
    {nr, nwe, lst, fst, gp} = '0;
    cs = 8'hff;
    @(posedge ref_clk_i);
    cpu_i <= '{ads_n: 1'b0, addr: a, wr: w, cache_n: c, byte_lane_en_n: b, sysmem: s, noncache: n};
    @(posedge ref_clk_i);
    cpu_i.ads_n <= 1'b1;
    for (t = 1; t < 150; t++) begin
      @(posedge ref_clk_i);
      #1;
      if (ex == 0 ? t > 30 : nr == ex && t > lst + 6) break;
      if (!burst_ready_n_o) begin
        if (nr == 0) fst = t;
        else gp = t - lst;
        if (nr < 4) {lsq[nr], osq[nr]} = {sram_addr_lsb_o, odd_bank_out_en_n_o};
        lst = t;
        nr++;
      end
      {req, line, cast} |= {mem_req_o, mem_req_o & mem_line_o, mem_castout_o};
      {post, mwr} |= {mem_posted_o, mem_req_o & mem_wr_o};
      {eoe, ooe} |= {!even_bank_out_en_n_o, !odd_bank_out_en_n_o};
      if (!tag_wr_en_n_o) {tagw, tg} = {1'b1, tag_o};
      if (!dirty_wr_en_n_o) dw = {1'b1, dirty_o};
      if (!odd_bank_wr_en_n_o || !even_bank_wr_en_n_o) {nwe, cs} = {nwe + 1, sram_cs_n_o};
    end
    if (t == 150) to();
    chk(nr, ex);
  endtask
  task automatic go(input logic w);
    run(A, w, w, 8'h00, 1'b1, 1'b0, w ? 1 : 4);
  endtask
  // ---------------
  // Sequence
  // ---------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(5'h03, 32'h0);
    rd(5'h17, 32'h0);
    wr(5'h1f, 32'hffffffff);
    rd(5'h1f, 32'h0);
    for (k = 3; k >= 0; k--) begin
      wr(5'h02, k << 4);
      rd(5'h02, k << 4);
    end
    cfg(3'h0, 2'h0, 1'b1, 1'b0, 1'b0);
    tm = tagof(A, 0);
    setx(tm, 1'b0);
    go(1'b0);
    f0 = fst;
    chk(gp, 2);
    chk({req, lsq, osq}, 9'h0ca);
    wr(5'h17, 32'h1);
    go(1'b0);
    chk(lsq, 4'h6);
    wr(5'h17, 32'h0);
    cfg(3'h0, 2'h2, 1'b1, 1'b0, 1'b0);
    go(1'b0);
    chk(fst, f0 + 2);
    cfg(3'h0, 2'h0, 1'b1, 1'b1, 1'b0);
    go(1'b0);
    chk(gp, 1);
    cfg(3'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    go(1'b0);
    chk({ooe, eoe, lsq}, 6'h15);
    run(A, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0, 1);
    cfg(3'h0, 2'h0, 1'b1, 1'b0, 1'b0);
    run(A, 1'b1, 1'b0, 8'hf0, 1'b1, 1'b0, 4);
    chk({req, dw}, 3'h3);
    chk({nwe[3:0], cs}, {4'h4, 8'hf0});
    run(A, 1'b1, 1'b1, 8'h0f, 1'b1, 1'b0, 1);
    chk(nwe, 1);
    wr(5'h02, 32'h10);
    go(1'b1);
    chk({mwr, dw[1], nwe[1:0]}, 4'h9);
    for (k = 0; k < 4; k++) begin
      ph <= (k != 3);
      ra <= (k == 1);
      wr(5'h02, k < 2 ? 32'h20 : 32'h30);
      go(1'b1);
      chk(mwr, k == 1 || k == 2);
      chk(nwe, 1);
    end
    wr(5'h02, 32'h0);
    setx(~tm, 1'b0);
    go(1'b1);
    chk({mwr, nwe[1:0], tagw, post}, 5'h10);
    wb <= 1'b1;
    cfg(3'h0, 2'h0, 1'b1, 1'b0, 1'b1);
    go(1'b1);
    chk(post, 1);
    go(1'b0);
    chk({line, cast, tagw, tg, nwe[2:0]}, {3'h5, tm, 3'h4});
    lt <= 4'h9;
    setx(~tm, 1'b1);
    go(1'b0);
    chk({cast, tagw}, 2'h3);
    lt <= 4'h4;
    setx(~tm, 1'b0);
    run(A, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0, 1);
    chk({req, line, tagw}, 3'h4);
    setx(tm, 1'b0);
    run(A, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1, 1);
    chk({req, tagw}, 2'h2);
    run(A, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 0);
    chk(req, 0);
    for (k = 0; k < 6; k++) begin
      cfg(k[2:0], 2'h0, 1'b1, 1'b0, 1'b0);
      setx(tagof(A, k), 1'b0);
      run(A, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0, 1);
      chk(req, 0);
    end
    setx(tm, 1'b0);
    run(A, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0, 1);
    chk(req, 1);
    summarize();
  end
endmodule
`default_nettype wire

// ---- hw/l2cc_top.sv ----
// Secondary-cache controller with Avalon-MM configuration slave
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`default_nettype none
module l2cc_top import l2cc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire l2cc_cpu_type cpu_i,
  input wire l2cc_ext_type ext_i,
  output logic burst_ready_n_o,
  output logic odd_bank_out_en_n_o,
  output logic even_bank_out_en_n_o,
  output logic odd_bank_wr_en_n_o,
  output logic even_bank_wr_en_n_o,
  output logic [7:0] sram_cs_n_o,
  output logic sram_addr_lsb_o,
  output logic [7:0] tag_o,
  output logic tag_wr_en_n_o,
  output logic dirty_o,
  output logic dirty_wr_en_n_o,
  output logic mem_req_o,
  output logic mem_wr_o,
  output logic mem_line_o,
  output logic mem_castout_o,
  output logic mem_posted_o
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  l2cc_cpu_type cpu_s1_reg, cpu_s2_reg;
  l2cc_ext_type ext_s1_reg, ext_s2_reg;

  always_ff @(posedge ref_clk_i) begin
    cpu_s1_reg <= cpu_i;
    cpu_s2_reg <= cpu_s1_reg;
    ext_s1_reg <= ext_i;
    ext_s2_reg <= ext_s1_reg;
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [1:0] policy_reg, policy_next;
  l2cc_ctrl_type ctrl_reg, ctrl_next;
  logic linear_reg, linear_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  l2cc_state_type state_reg, state_next;
  logic [31:0] merged;
  logic [31:0] lane_mask;
  logic [4:0] idx;

  always_comb begin
    idx = avs_address_i[6:2];
    lane_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                 {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    merged = 32'h0000_0000;
    policy_next = policy_reg;
    ctrl_next = ctrl_reg;
    linear_next = linear_reg;
    rdata_next = rdata_reg;
    wait_next = 1'b1;
    // One wait cycle; the request is taken with waitrequest low
    if ((avs_read_i || avs_write_i) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = 32'h0000_0000;
      case (idx)
        IDX_POLICY: rdata_next[POLICY_LSB +: 2] = policy_reg;
        IDX_CTRL: rdata_next[8:0] = ctrl_reg;
        IDX_STATUS: rdata_next[4:0] = {state_reg != ST_IDLE, hit_reg, state_reg};
        IDX_BURST: rdata_next[BURST_LINEAR_BIT] = linear_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && !wait_reg) begin
      case (idx)
        // [RULE17] policy field write
        IDX_POLICY: begin
          merged[POLICY_LSB +: 2] = policy_reg;
          merged = (merged & ~lane_mask) | (avs_writedata_i & lane_mask);
          policy_next = merged[POLICY_LSB +: 2];
        end
        IDX_CTRL: begin
          merged[8:0] = ctrl_reg;
          merged = (merged & ~lane_mask) | (avs_writedata_i & lane_mask);
          ctrl_next = merged[8:0];
        end
        // [RULE24] burst order select
        IDX_BURST: begin
          if (avs_byteenable_i[0]) begin
            linear_next = avs_writedata_i[BURST_LINEAR_BIT];
          end
        end
        default: merged = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      policy_reg <= POLICY_RST;
      ctrl_reg <= CTRL_RST;
      linear_reg <= BURST_RST;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      policy_reg <= policy_next;
      ctrl_reg <= ctrl_next;
      linear_reg <= linear_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Tag expectation per cache size
  // ---------------------------------------------------------------
  l2cc_cpu_type req_reg, req_next;
  logic [7:0] exp_tag;

  // [RULE21] upper three tag bits fixed
  assign exp_tag[7:5] = req_reg.addr[23:21];
  for (genvar i = 0; i < TAG_MOVABLE; i++) begin : g_tag
    // [RULE22] larger sizes move bit i up
    assign exp_tag[i] = (ctrl_reg.size > 3'(i)) ? req_reg.addr[24 + i] : req_reg.addr[16 + i];
  end

  function automatic logic [1:0] beat_qw(input logic [1:0] start, input logic [1:0] beat, input logic lin);
    beat_qw = lin ? 2'(start + beat) : (start ^ beat);
  endfunction

  // ---------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------
  logic burst_reg, burst_next;
  logic cwr_reg, cwr_next;
  logic crd_reg, crd_next;
  logic [1:0] beat_reg, beat_next;
  logic [1:0] cnt_reg, cnt_next;
  logic burst_ready_n_reg, burst_ready_n_next;
  logic [1:0] oe_reg, oe_next;
  logic [1:0] we_reg, we_next;
  logic [7:0] cs_reg, cs_next;
  logic lsb_reg, lsb_next;
  logic [7:0] tag_reg, tag_next;
  logic tagwr_reg, tagwr_next;
  logic dirty_reg, dirty_next;
  logic dirtywr_reg, dirtywr_next;
  logic mreq_reg, mreq_next;
  logic mwr_reg, mwr_next;
  logic mline_reg, mline_next;
  logic mcast_reg, mcast_next;
  logic mpost_reg, mpost_next;
  logic cacheable, hit, dirty_line, thru, fill_wr, rd_c, wr_c, bank;
  logic [1:0] qbeat, qw, last;

  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    burst_next = burst_reg;
    cwr_next = cwr_reg;
    crd_next = crd_reg;
    beat_next = beat_reg;
    cnt_next = cnt_reg;
    hit_next = hit_reg;
    burst_ready_n_next = 1'b1;
    tag_next = tag_reg;
    tagwr_next = 1'b1;
    dirty_next = dirty_reg;
    dirtywr_next = 1'b1;
    mreq_next = 1'b0;
    mwr_next = mwr_reg;
    mline_next = mline_reg;
    mcast_next = mcast_reg;
    mpost_next = 1'b0;
    fill_wr = 1'b0;
    last = burst_reg ? LAST_BEAT : FIRST_BEAT;
    // [RULE23] cacheable: system memory, outside holes
    cacheable = req_reg.sysmem && !req_reg.noncache && ctrl_reg.cache_en;
    hit = cacheable && (ext_s2_reg.tag == exp_tag);
    dirty_line = ext_s2_reg.dirty && (policy_reg != POL_WRITE_THROUGH);
    // [RULE18] adaptive write-through decision
    case (policy_reg)
      POL_WRITE_THROUGH: thru = 1'b1;
      // [RULE19] page hit with row strobe active
      POL_ADAPTIVE_WB_ROW_ACTIVE: thru = ext_s2_reg.page_hit && ext_s2_reg.row_active;
      // [RULE20] any page hit
      POL_ADAPTIVE_WB_PAGE_ONLY: thru = ext_s2_reg.page_hit;
      default: thru = 1'b0;
    endcase
    case (state_reg)
      ST_IDLE: begin
        if (!cpu_s2_reg.ads_n) begin
          // [RULE1] cacheable-cycle sampled with the strobe
          req_next = cpu_s2_reg;
          burst_next = !cpu_s2_reg.cache_n;
          beat_next = FIRST_BEAT;
          cwr_next = 1'b0;
          crd_next = 1'b0;
          state_next = ST_T2;
        end
      end
      ST_T2: begin
        // [RULE3] tag compare sampled here
        hit_next = hit;
        tag_next = exp_tag;
        if (!req_reg.sysmem) begin
          // [RULE16] not ours
          state_next = ST_IDLE;
        end else if (!req_reg.wr) begin
          if (hit) begin
            crd_next = 1'b1;
            state_next = ST_LEAD;
          end else if (burst_reg && cacheable) begin
            mreq_next = 1'b1;
            mline_next = 1'b1;
            tagwr_next = 1'b0;
            dirtywr_next = 1'b0;
            dirty_next = 1'b0;
            if (dirty_line) begin
              // [RULE14] castout first, tag and dirty updated now
              mwr_next = 1'b1;
              mcast_next = 1'b1;
              state_next = ST_CAST;
            end else begin
              // [RULE12] clean linefill
              mwr_next = 1'b0;
              mcast_next = 1'b0;
              state_next = ST_FILL;
            end
          end else begin
            // [RULE13] eight bytes only, no tag change
            mreq_next = 1'b1;
            mwr_next = 1'b0;
            mline_next = 1'b0;
            mcast_next = 1'b0;
            burst_next = 1'b0;
            state_next = ST_MEM;
          end
        end else if (hit) begin
          // [RULE17] cache always written on a hit
          cwr_next = 1'b1;
          if (thru) begin
            // [RULE7] memory first, burst-ready afterwards
            mreq_next = 1'b1;
            mwr_next = 1'b1;
            mline_next = burst_reg;
            mcast_next = 1'b0;
            state_next = ST_MEM;
          end else begin
            // [RULE8] cache only, line made dirty
            dirtywr_next = 1'b0;
            dirty_next = 1'b1;
            state_next = ST_LEAD;
          end
        end else begin
          // [RULE15] write miss to memory only
          mreq_next = 1'b1;
          mwr_next = 1'b1;
          mline_next = 1'b0;
          mcast_next = 1'b0;
          burst_next = 1'b0;
          if (ctrl_reg.post_en && ext_s2_reg.wbuf_avail) begin
            mpost_next = 1'b1;
            state_next = ST_LEAD;
          end else begin
            state_next = ST_MEM;
          end
        end
        // [RULE4] programmed wait states before first ready
        if (state_next == ST_LEAD) begin
          if (ctrl_reg.waits == 2'h0) begin
            state_next = ST_BEAT;
            burst_ready_n_next = 1'b0;
          end else begin
            cnt_next = ctrl_reg.waits - 2'h1;
          end
        end
      end
      ST_LEAD: begin
        if (cnt_reg == 2'h0) begin
          state_next = ST_BEAT;
          burst_ready_n_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      ST_BEAT: begin
        // [RULE2] one wait state between beats
        if (beat_reg == last) begin
          state_next = ST_IDLE;
          cwr_next = 1'b0;
          crd_next = 1'b0;
        end else begin
          beat_next = beat_reg + 2'h1;
          // [RULE9] sync SRAM drops the inter-beat wait
          if (ctrl_reg.sync_sram) begin
            burst_ready_n_next = 1'b0;
          end else begin
            cnt_next = 2'h0;
            state_next = ST_LEAD;
          end
        end
      end
      ST_MEM: begin
        mreq_next = !ext_s2_reg.mem_done;
        if (ext_s2_reg.mem_done) begin
          state_next = ST_BEAT;
          burst_ready_n_next = 1'b0;
        end
      end
      ST_CAST: begin
        mreq_next = 1'b1;
        if (ext_s2_reg.mem_beat) begin
          beat_next = beat_reg + 2'h1;
          if (beat_reg == LAST_BEAT) begin
            mwr_next = 1'b0;
            mcast_next = 1'b0;
            state_next = ST_FILL;
          end
        end
      end
      ST_FILL: begin
        mreq_next = 1'b1;
        if (ext_s2_reg.mem_beat) begin
          burst_ready_n_next = 1'b0;
          fill_wr = 1'b1;
          beat_next = beat_reg + 2'h1;
          if (beat_reg == LAST_BEAT) begin
            mreq_next = 1'b0;
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Strobes use the next beat, or the current beat on a fill write, to leave the flops aligned with ready
    qbeat = fill_wr ? beat_reg : beat_next;
    // [RULE24] interleaved or linear quad-word order
    qw = beat_qw(req_next.addr[4:3], qbeat, linear_reg);
    rd_c = (crd_next && (state_next == ST_LEAD || state_next == ST_BEAT)) || state_next == ST_CAST;
    wr_c = (cwr_next && state_next == ST_BEAT) || fill_wr;
    // [RULE5] two banks use A4 as low address, A3 as bank
    // [RULE6] one bank uses A3 and stays on the even bank
    lsb_next = ctrl_reg.two_bank ? qw[1] : qw[0];
    bank = ctrl_reg.two_bank && qw[0];
    oe_next = ~{rd_c && bank, rd_c && !bank};
    // [RULE10] bank write enables from A3
    we_next = ~{wr_c && bank, wr_c && !bank};
    // [RULE11] byte enables gate chip selects on writes
    cs_next = wr_c ? req_next.byte_lane_en_n : (rd_c ? 8'h00 : 8'hff);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
      burst_reg <= 1'b0;
      cwr_reg <= 1'b0;
      crd_reg <= 1'b0;
      beat_reg <= 2'h0;
      cnt_reg <= 2'h0;
      hit_reg <= 1'b0;
      burst_ready_n_reg <= 1'b1;
      oe_reg <= 2'h3;
      we_reg <= 2'h3;
      cs_reg <= 8'hff;
      lsb_reg <= 1'b0;
      tag_reg <= 8'h00;
      tagwr_reg <= 1'b1;
      dirty_reg <= 1'b0;
      dirtywr_reg <= 1'b1;
      mreq_reg <= 1'b0;
      mwr_reg <= 1'b0;
      mline_reg <= 1'b0;
      mcast_reg <= 1'b0;
      mpost_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      burst_reg <= burst_next;
      cwr_reg <= cwr_next;
      crd_reg <= crd_next;
      beat_reg <= beat_next;
      cnt_reg <= cnt_next;
      hit_reg <= hit_next;
      burst_ready_n_reg <= burst_ready_n_next;
      oe_reg <= oe_next;
      we_reg <= we_next;
      cs_reg <= cs_next;
      lsb_reg <= lsb_next;
      tag_reg <= tag_next;
      tagwr_reg <= tagwr_next;
      dirty_reg <= dirty_next;
      dirtywr_reg <= dirtywr_next;
      mreq_reg <= mreq_next;
      mwr_reg <= mwr_next;
      mline_reg <= mline_next;
      mcast_reg <= mcast_next;
      mpost_reg <= mpost_next;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign burst_ready_n_o = burst_ready_n_reg;
  assign odd_bank_out_en_n_o = oe_reg[1];
  assign even_bank_out_en_n_o = oe_reg[0];
  assign odd_bank_wr_en_n_o = we_reg[1];
  assign even_bank_wr_en_n_o = we_reg[0];
  assign sram_cs_n_o = cs_reg;
  assign sram_addr_lsb_o = lsb_reg;
  assign tag_o = tag_reg;
  assign tag_wr_en_n_o = tagwr_reg;
  assign dirty_o = dirty_reg;
  assign dirty_wr_en_n_o = dirtywr_reg;
  assign mem_req_o = mreq_reg;
  assign mem_wr_o = mwr_reg;
  assign mem_line_o = mline_reg;
  assign mem_castout_o = mcast_reg;
  assign mem_posted_o = mpost_reg;
endmodule
`default_nettype wire
